//--- design/timer_event_counter_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef TIMER_EVENT_COUNTER_CFG_SVH
`define TIMER_EVENT_COUNTER_CFG_SVH
`define COUNTER0_HIGH_BYTE_ADDR 8'h0c
`define COUNTER0_LOW_BYTE_ADDR 8'h0d
`define COUNTER8_PRELOAD_AND_COUNT_ADDR 8'h0d
`define COUNTER0_CONTROL_ADDR 8'h0e
`define COUNTER8_CONTROL_ADDR 8'h0e
`define COUNTER1_HIGH_BYTE_ADDR 8'h0f
`define COUNTER1_LOW_BYTE_ADDR 8'h10
`define COUNTER1_CONTROL_ADDR 8'h11
`define MODE_SELECT_HIGH_BIT 7
`define MODE_SELECT_LOW_BIT 6
`define RUN_ENABLE_BIT 4
`define ACTIVE_EDGE_POLARITY_BIT 3
`define CONTROL_RESET 8'h08
`define CONTROL_READ_MASK 8'hd8
`define INSTR_CLOCK_DIVIDE 2'h3
`endif

//--- design/timer_event_counter_pkg.sv
// Types shared by the timer and event counter.
package timer_event_counter_pkg;
	typedef enum logic [1:0] {
		mode_unused = 2'h0,
		mode_event = 2'h1,
		mode_timer = 2'h2,
		mode_pulse = 2'h3
	} mode_t;
	typedef enum {
		pulse_idle,
		pulse_measure,
		pulse_done
	} pulse_state_t;
endpackage

//--- design/timer_event_counter.sv
// Timer and event counter block with two counters and a register port.
`timescale 1ns/1ns
`include "timer_event_counter_cfg.svh"
module timer_event_counter #(
	parameter int WIDTH0 = 16,
	parameter int WIDTH1 = 16,
	parameter bit TWO_COUNTERS = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] address,
	input wire logic [7:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [7:0] read_data,
	input wire logic counter0_input_pin,
	input wire logic counter1_input_pin,
	output logic [1:0] overflow_request
);
	import timer_event_counter_pkg::*;

	localparam int W[2] = '{WIDTH0, WIDTH1};

	logic [1:0] prescale;
	logic [1:0] next_prescale;
	logic tick;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] pin_last;
	logic [1:0] next_pin_meta;
	logic [1:0] next_pin_sync;
	logic [1:0] next_pin_last;
	logic [1:0] hit_ctrl_wr;
	logic [1:0] hit_low_wr;
	logic [1:0] hit_high_wr;
	logic [1:0] hit_high_rd;
	logic [15:0] count [2];
	logic [15:0] next_count [2];
	logic [15:0] preload [2];
	logic [15:0] next_preload [2];
	logic [7:0] low_buffer [2];
	logic [7:0] next_low_buffer [2];
	logic [7:0] control [2];
	logic [7:0] next_control [2];
	pulse_state_t pulse [2];
	pulse_state_t next_pulse [2];
	logic [7:0] read_value;
	logic [7:0] next_read_data;
	logic [1:0] next_overflow;

	function automatic logic [15:0] width_mask(input int w);
		if (w >= 16) begin
			width_mask = 16'hffff;
		end else begin
			width_mask = 16'h00ff;
		end
	endfunction

	function automatic logic [7:0] high_addr(input int i);
		if (i == 0) begin
			high_addr = `COUNTER0_HIGH_BYTE_ADDR;
		end else begin
			high_addr = `COUNTER1_HIGH_BYTE_ADDR;
		end
	endfunction

	function automatic logic [7:0] low_addr(input int i);
		if (i == 0) begin
			low_addr = `COUNTER0_LOW_BYTE_ADDR;
		end else begin
			low_addr = `COUNTER1_LOW_BYTE_ADDR;
		end
	endfunction

	function automatic logic [7:0] ctrl_addr(input int i);
		if (i == 0) begin
			ctrl_addr = `COUNTER0_CONTROL_ADDR;
		end else begin
			ctrl_addr = `COUNTER1_CONTROL_ADDR;
		end
	endfunction

	always_comb begin
		next_prescale = prescale + 2'h1;
	end
	assign tick = (prescale == `INSTR_CLOCK_DIVIDE);

	// The divider runs free, so register writes never shift the time-base.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prescale <= 2'h0;
		end else begin
			prescale <= next_prescale;
		end
	end

	always_comb begin
		next_pin_meta = {counter1_input_pin, counter0_input_pin};
		next_pin_sync = pin_meta;
		next_pin_last = pin_sync;
	end

	// Resetting to the low idle level avoids a false edge after reset.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
			pin_last <= 2'h0;
		end else begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
			pin_last <= next_pin_last;
		end
	end

	// Address decode shared by the write and latch paths.
	always_comb begin
		hit_ctrl_wr = 2'h0;
		hit_low_wr = 2'h0;
		hit_high_wr = 2'h0;
		hit_high_rd = 2'h0;
		for (int i = 0; i < 2; i++) begin
			if (i == 0 || TWO_COUNTERS) begin
				if (address == ctrl_addr(i)) begin
					hit_ctrl_wr[i] = write_strobe;
				end else if (address == low_addr(i)) begin
					hit_low_wr[i] = write_strobe;
				end else if (address == high_addr(i) && W[i] >= 16) begin
					hit_high_wr[i] = write_strobe;
					hit_high_rd[i] = read_strobe;
				end
			end
		end
	end

	// Register read mux; reserved control bits are masked to zero.
	always_comb begin
		read_value = 8'h00;
		for (int i = 0; i < 2; i++) begin
			if (i == 0 || TWO_COUNTERS) begin
				if (address == ctrl_addr(i)) begin
					read_value = control[i] & `CONTROL_READ_MASK;
				end else if (address == high_addr(i) && W[i] >= 16) begin
					read_value = count[i][15:8];
				end else if (address == low_addr(i)) begin
					read_value = (W[i] >= 16) ? low_buffer[i]
						: count[i][7:0];
				end
			end
		end
		next_read_data = read_strobe ? read_value : 8'h00;
	end

	always_comb begin
		logic mode_bits_h;
		logic edge_hit;
		logic level_on;
		logic advance;
		logic [15:0] mask;
		mode_t mode;
		mode_bits_h = 1'b0;
		edge_hit = 1'b0;
		level_on = 1'b0;
		advance = 1'b0;
		mask = 16'h0000;
		mode = mode_unused;
		next_overflow = 2'h0;
		for (int i = 0; i < 2; i++) begin
			next_count[i] = count[i];
			next_preload[i] = preload[i];
			next_low_buffer[i] = low_buffer[i];
			next_control[i] = control[i];
			next_pulse[i] = pulse[i];
			mask = width_mask(W[i]);
			mode = mode_t'({control[i][`MODE_SELECT_HIGH_BIT],
				control[i][`MODE_SELECT_LOW_BIT]});
			mode_bits_h = control[i][`ACTIVE_EDGE_POLARITY_BIT];
			edge_hit = mode_bits_h ? (pin_last[i] & ~pin_sync[i])
				: (~pin_last[i] & pin_sync[i]);
			level_on = mode_bits_h ? ~pin_sync[i] : pin_sync[i];
			advance = 1'b0;
			if (control[i][`RUN_ENABLE_BIT]) begin
				case (mode)
					mode_event: advance = edge_hit;
					mode_timer: advance = tick;
					mode_pulse: begin
						case (pulse[i])
							pulse_idle: begin
								if (edge_hit) begin
									next_pulse[i] = pulse_measure;
								end
							end
							pulse_measure: begin
								if (!level_on) begin
									next_pulse[i] = pulse_done;
									next_control[i][`RUN_ENABLE_BIT] = 1'b0;
								end else begin
									advance = tick;
								end
							end
							default: next_pulse[i] = pulse_done;
						endcase
					end
					default: advance = 1'b0;
				endcase
			end else begin
				next_pulse[i] = pulse_idle;
			end
			if (advance) begin
				if ((count[i] & mask) == mask) begin
					next_count[i] = preload[i] & mask;
					next_overflow[i] = 1'b1;
				end else begin
					next_count[i] = (count[i] + 16'h0001) & mask;
				end
			end
			if (hit_ctrl_wr[i]) begin
				next_control[i] = write_data & `CONTROL_READ_MASK;
			end else if (hit_low_wr[i] && W[i] >= 16) begin
				next_low_buffer[i] = write_data;
			end else if (hit_low_wr[i]) begin
				next_preload[i] = {8'h00, write_data};
				if (!control[i][`RUN_ENABLE_BIT]) begin
					next_count[i] = {8'h00, write_data};
				end
			end else if (hit_high_wr[i]) begin
				next_preload[i] = {write_data, low_buffer[i]};
				if (!control[i][`RUN_ENABLE_BIT]) begin
					next_count[i] = {write_data, low_buffer[i]};
				end
			end else if (hit_high_rd[i]) begin
				// latch low byte
				// A running counter would tear a two-byte read without this.
				next_low_buffer[i] = count[i][7:0];
			end
		end
	end

	// Software must read the high byte first to get a coherent pair.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			read_data <= 8'h00;
			overflow_request <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				count[i] <= 16'h0000;
				preload[i] <= 16'h0000;
				low_buffer[i] <= 8'h00;
				control[i] <= `CONTROL_RESET;
				pulse[i] <= pulse_idle;
			end
		end else begin
			read_data <= next_read_data;
			overflow_request <= next_overflow;
			for (int i = 0; i < 2; i++) begin
				count[i] <= next_count[i];
				preload[i] <= next_preload[i];
				low_buffer[i] <= next_low_buffer[i];
				control[i] <= next_control[i];
				pulse[i] <= next_pulse[i];
			end
		end
	end
endmodule

//--- tb/pin_source.sv
// Model of the external event or pulse source on an input pin.
`timescale 1ns/1ns
module pin_source (
	input wire logic clk,
	output logic pin
);
	// The pin idles low between pulses, as a pulled-down input would.
	initial pin = 1'b0;
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (w) @(posedge clk);
			pin <= 1'b0;
			repeat (w) @(posedge clk);
		end
	endtask
endmodule

//--- tb/timer_event_counter_properties.sv
// Checker of the register port and overflow pulses.
`timescale 1ns/1ns
module timer_event_counter_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] address,
	input wire logic [7:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] read_data,
	input wire logic [1:0] overflow_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	read_idle_a: assert property (!read_strobe |=> read_data == 8'h00)
		else $error("read data not idle");
	unmapped_zero_a: assert property (read_strobe && address > 8'h11
		|=> read_data == 8'h00) else $error("unmapped read not zero");
	ctrl_spare_a: assert property (read_strobe && (address == 8'h0e ||
		address == 8'h11) |=> (read_data & 8'h27) == 8'h00)
		else $error("spare control bits set");
	ctrl0_back_a: assert property (write_strobe && address == 8'h0e &&
		write_data[7:6] != 2'h3 ##2 read_strobe && address == 8'h0e
		|=> read_data == ($past(write_data, 3) & 8'hd8))
		else $error("control 0 readback wrong");
	ctrl1_back_a: assert property (write_strobe && address == 8'h11 &&
		write_data[7:6] != 2'h3 ##2 read_strobe && address == 8'h11
		|=> read_data == ($past(write_data, 3) & 8'hd8))
		else $error("control 1 readback wrong");
	ovf0_pulse_a: assert property (overflow_request[0]
		|=> !overflow_request[0]) else $error("overflow 0 too long");
	ovf1_pulse_a: assert property (overflow_request[1]
		|=> !overflow_request[1]) else $error("overflow 1 too long");
	stopped_quiet_a: assert property (write_strobe && address == 8'h0e &&
		!write_data[4] |-> ##2 !overflow_request[0] [*6])
		else $error("stopped counter overflowed");
	cover property (overflow_request[0]);
	cover property (read_strobe && address == 8'h0c);
	cover property (write_strobe && address == 8'h11);
endmodule
bind timer_event_counter timer_event_counter_properties chk (.clk(clk),
	.reset(reset), .address(address), .write_data(write_data),
	.write_strobe(write_strobe), .read_strobe(read_strobe),
	.read_data(read_data), .overflow_request(overflow_request));

//--- tb/tb.sv
// Bench for the timer and event counter.
`timescale 1ns/1ns
module tb;
	logic clk, reset, write_strobe, read_strobe, pin0, pin1;
	logic [7:0] address, write_data, read_data, seen;
	logic [1:0] overflow_request;
	int err_total, n_compared, cycles, ovf0, ovf1;
	timer_event_counter dut (.clk(clk), .reset(reset), .address(address),
		.write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data),
		.counter0_input_pin(pin0), .counter1_input_pin(pin1),
		.overflow_request(overflow_request));
	pin_source src0 (.clk(clk), .pin(pin0));
	pin_source src1 (.clk(clk), .pin(pin1));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (overflow_request[0] === 1'b1) ovf0++;
		if (overflow_request[1] === 1'b1) ovf1++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1 seen = read_data;
	endtask
	task automatic rc(input logic [7:0] a, e);
		rd(a);
		chk($sformatf("reg %h", a), seen, e);
	endtask
	initial begin
		reset = 1'b1;
		address = 8'h00;
		write_data = 8'h00;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rc(8'h0e, 8'h08);
		rc(8'h11, 8'h08);
		wr(8'h12, 8'hff);
		rc(8'h12, 8'h00);
		wr(8'h0d, 8'hfe);
		wr(8'h0c, 8'hff);
		rc(8'h0c, 8'hff);
		rc(8'h0d, 8'hfe);
		wr(8'h0d, 8'h00);
		$display("test access done");
		wr(8'h0e, 8'h7f);
		rc(8'h0e, 8'h58);
		src0.pulse(3, 3);
		repeat (5) @(posedge clk);
		rc(8'h0c, 8'hff);
		src0.pulse(1, 3);
		repeat (5) @(posedge clk);
		rc(8'h0d, 8'hff);
		chk("overflows", 16'(ovf0), 16'h2);
		rc(8'h0c, 8'hff);
		rc(8'h0d, 8'hfe);
		$display("test event done");
		wr(8'h0e, 8'hc0);
		wr(8'h0d, 8'h00);
		wr(8'h0c, 8'h00);
		wr(8'h0e, 8'hd0);
		src0.pulse(1, 40);
		repeat (8) @(posedge clk);
		rc(8'h0e, 8'hc0);
		rc(8'h0c, 8'h00);
		rd(8'h0d);
		chk("pulse count", 16'(seen >= 8'd9 && seen <= 8'd11), 16'h1);
		$display("test pulse done");
		wr(8'h10, 8'h00);
		wr(8'h0f, 8'h00);
		wr(8'h11, 8'hb7);
		rc(8'h11, 8'h90);
		repeat (36) @(posedge clk);
		wr(8'h11, 8'h80);
		rc(8'h0f, 8'h00);
		rd(8'h10);
		chk("timer count", 16'(seen >= 8'd9 && seen <= 8'd11), 16'h1);
		$display("test timer done");
		wr(8'h10, 8'hfe);
		wr(8'h0f, 8'hff);
		wr(8'h11, 8'h50);
		src1.pulse(2, 3);
		repeat (5) @(posedge clk);
		wr(8'h11, 8'h00);
		rc(8'h0f, 8'hff);
		rc(8'h10, 8'hfe);
		chk("overflows 1", 16'(ovf1), 16'h1);
		$display("test counter1 event done");
		results();
	end
endmodule
